// [design/uef_pkg.sv]
package uef_pkg;

   // Register byte offsets: each register has clear, set and invert aliases
   localparam logic [7:0] FLAGS_OFS     = 8'h00;
   localparam logic [7:0] ENABLES_OFS   = 8'h10;
   localparam logic [7:0] CONTROL_OFS   = 8'h20;
   localparam logic [7:0] STATE_OFS     = 8'h30;
   localparam logic [7:0] ALIAS_CLR_OFS = 8'h04;
   localparam logic [7:0] ALIAS_SET_OFS = 8'h08;
   localparam logic [7:0] ALIAS_INV_OFS = 8'h0c;
   localparam logic [7:0] BASE_MASK     = 8'hf0;
   localparam logic [7:0] ALIAS_MASK    = 8'h0c;

   // Event bit positions, shared by the flag and enable registers
   localparam int ID_CHANGE_BIT     = 7;
   localparam int MS_TIMER_BIT      = 6;
   localparam int LINE_STABLE_BIT   = 5;
   localparam int BUS_ACTIVITY_BIT  = 4;
   localparam int SESSION_VALID_BIT = 3;
   localparam int B_SESS_END_BIT    = 2;
   localparam int A_VBUS_VALID_BIT  = 0;

   // Control register: bit 0 arms wake-up on bus activity
   localparam int WAKE_ARM_BIT = 0;

   // Implemented bits; bit 1 and bits 31..8 read zero
   localparam logic [7:0]  EVENT_MASK    = 8'hfd;
   localparam logic [7:0]  CONTROL_MASK  = 8'h01;
   localparam logic [7:0]  EVENT_RESET   = 8'h00;
   localparam logic [7:0]  CONTROL_RESET = 8'h00;
   localparam logic [31:0] READ_ZERO     = 32'h0000_0000;
   localparam logic [23:0] UPPER_ZERO    = 24'h00_0000;

   // Pin vector layout as seen by the synchroniser
   localparam int PIN_COUNT    = 5;
   localparam int PIN_ID       = 0;
   localparam int PIN_DPLUS    = 1;
   localparam int PIN_DMINUS   = 2;
   localparam int PIN_SESS_VLD = 3;
   localparam int PIN_SESS_END = 4;

   // One millisecond at a 100 ns clock
   localparam longint CLK_PERIOD_PS = 100_000;
   localparam longint MS_TIME_PS    = 1_000_000_000;
   localparam int     MS_CYCLES     = int'(MS_TIME_PS / CLK_PERIOD_PS);
   localparam int     MS_CNT_W      = 24;

   // Kind of register write decoded from the alias offset
   typedef enum logic [1:0] {WR_PLAIN, WR_CLEAR, WR_SET, WR_INVERT} uef_wr_kind_t;

endpackage : uef_pkg

// [design/uef_sync.sv]
`timescale 1ns/1ns
// Two-stage synchroniser for asynchronous pin levels
module uef_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clock,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] pinAsync,
   output logic      [WIDTH-1:0] pinSync
);

   logic [WIDTH-1:0] meta_ff;
   logic [WIDTH-1:0] sync_ff;

   // First stage is read only by the second stage
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         meta_ff <= '0;
         sync_ff <= '0;
      end
      else
      begin
         meta_ff <= pinAsync;
         sync_ff <= meta_ff;
      end
   end

   assign pinSync = sync_ff;

endmodule : uef_sync

// [design/uef_top.sv]
`timescale 1ns/1ns
// What this block does
// - Set ID change flag, bit 7, whenever the synchronised ID pin changes.
// - Set timer flag, bit 6, each time the free-running 1 ms timer expires.
// - Set line flag, bit 5, when line state holds 1 ms and differs from last.
// - Set activity flag, bit 4, when D+, D-, ID or session valid comparator activity wakes device.
// - Set session-valid flag, bit 3, when VBUS drops below session end level.
// - Set B session end flag, bit 2, on any session end comparator change.
// - Set A VBUS flag, bit 0, on any session valid comparator change.
// - Flags set only by hardware; writing one clears, writing zero keeps.
// - Bits 31..8 and bit 1 of both registers read zero, ignore writes.
// - Enable bits 7 and 6 gate ID change and timer events.
// - Enable bits 5 and 4 gate line-state and bus activity events.
// - Enable bits 3, 2 and 0 gate session and VBUS events.
// - Clear, set and invert aliases at offsets 4, 8 and c per register.
module uef_top #(
   parameter int MS_CYCLES = uef_pkg::MS_CYCLES
) (
   input  wire logic        clock,
   input  wire logic        rst_n,
   input  wire logic [7:0]  regAddr,
   input  wire logic [31:0] regWrData,
   input  wire logic        regWrite,
   input  wire logic        regRead,
   output logic      [31:0] regRdData,
   input  wire logic        idPin,
   input  wire logic        dPlusPin,
   input  wire logic        dMinusPin,
   input  wire logic        sessValidCmp,
   input  wire logic        sessEndCmp,
   output logic             otgIrq
);

   // Decode of a byte address into its alias kind
   function automatic uef_pkg::uef_wr_kind_t aliasKind(input logic [7:0] addr);
      logic [7:0] sel;
      sel = addr & uef_pkg::ALIAS_MASK;
      case (sel)
         uef_pkg::ALIAS_CLR_OFS: aliasKind = uef_pkg::WR_CLEAR;
         uef_pkg::ALIAS_SET_OFS: aliasKind = uef_pkg::WR_SET;
         uef_pkg::ALIAS_INV_OFS: aliasKind = uef_pkg::WR_INVERT;
         default:                aliasKind = uef_pkg::WR_PLAIN;
      endcase
   endfunction : aliasKind

   // New value of a plain read/write register after a write of any kind
   function automatic logic [7:0] applyWrite(
      input logic [7:0]            cur,
      input logic [7:0]            data,
      input logic [7:0]            mask,
      input uef_pkg::uef_wr_kind_t kind
   );
      logic [7:0] res;
      res = cur;
      case (kind)
         uef_pkg::WR_PLAIN:  res = data;
         uef_pkg::WR_CLEAR:  res = cur & ~data;
         uef_pkg::WR_SET:    res = cur | data;
         uef_pkg::WR_INVERT: res = cur ^ data;
         default:            res = cur;
      endcase
      applyWrite = res & mask;
   endfunction : applyWrite

   // Bits that software asks to clear in the flag register
   function automatic logic [7:0] flagClears(
      input logic [7:0]            cur,
      input logic [7:0]            data,
      input uef_pkg::uef_wr_kind_t kind
   );
      logic [7:0] res;
      res = 8'h00;
      case (kind)
         uef_pkg::WR_PLAIN:  res = data;
         uef_pkg::WR_CLEAR:  res = data;
         uef_pkg::WR_SET:    res = 8'h00;
         uef_pkg::WR_INVERT: res = data & cur;
         default:            res = 8'h00;
      endcase
      flagClears = res & uef_pkg::EVENT_MASK;
   endfunction : flagClears

   localparam logic [uef_pkg::MS_CNT_W-1:0] MS_LAST =
      uef_pkg::MS_CNT_W'(MS_CYCLES - 1);

   logic [uef_pkg::PIN_COUNT-1:0] pinSync;
   logic [uef_pkg::PIN_COUNT-1:0] pinPrev_ff;
   logic                          pinPrimed_ff;
   logic [1:0]                    primeDly_ff;
   logic [7:0]                    flags_ff;
   logic [7:0]                    nxt_flags;
   logic [7:0]                    enables_ff;
   logic [7:0]                    control_ff;
   logic [31:0]                   rdData_ff;
   logic [31:0]                   nxt_rdData;
   logic                          irq_ff;
   logic [uef_pkg::MS_CNT_W-1:0]  msCnt_ff;
   logic [uef_pkg::MS_CNT_W-1:0]  lineCnt_ff;
   logic [1:0]                    lineStable_ff;
   logic                          lineArmed_ff;
   logic [7:0]                    baseAddr;
   uef_pkg::uef_wr_kind_t         wrKind;
   logic                          wrFlags;
   logic                          wrEnables;
   logic                          wrControl;
   logic [7:0]                    events;
   logic [7:0]                    clears;
   logic [uef_pkg::PIN_COUNT-1:0] pinChange;
   logic [1:0]                    lineNow;
   logic [1:0]                    linePrev;
   logic                          msTick;
   logic                          lineSettled;

   // Every pin is asynchronous to this clock
   uef_sync #(
      .WIDTH (uef_pkg::PIN_COUNT)
   ) u_pin_sync (
      .clock    (clock),
      .rst_n    (rst_n),
      .pinAsync ({sessEndCmp, sessValidCmp, dMinusPin, dPlusPin, idPin}),
      .pinSync  (pinSync)
   );

   // Register address decode
   assign baseAddr  = regAddr & uef_pkg::BASE_MASK;
   assign wrKind    = aliasKind(regAddr);
   assign wrFlags   = regWrite && (baseAddr == uef_pkg::FLAGS_OFS);
   assign wrEnables = regWrite && (baseAddr == uef_pkg::ENABLES_OFS);
   assign wrControl = regWrite && (baseAddr == uef_pkg::CONTROL_OFS);

   // Previous pin levels; change detection waits until both synchroniser
   // stages and this register hold real pin samples, so a pin that is
   // already high when reset ends does not look like a change
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         pinPrev_ff   <= '0;
         primeDly_ff  <= '0;
         pinPrimed_ff <= 1'b0;
      end
      else
      begin
         pinPrev_ff   <= pinSync;
         primeDly_ff  <= {primeDly_ff[0], 1'b1};
         pinPrimed_ff <= primeDly_ff[1];
      end
   end

   assign pinChange = pinPrimed_ff ? (pinSync ^ pinPrev_ff) : '0;
   assign lineNow   = {pinSync[uef_pkg::PIN_DPLUS], pinSync[uef_pkg::PIN_DMINUS]};
   assign linePrev  = {pinPrev_ff[uef_pkg::PIN_DPLUS], pinPrev_ff[uef_pkg::PIN_DMINUS]};

   // Free-running 1 ms timer; expiry is a one-cycle tick
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         msCnt_ff <= '0;
      end
      else if (msCnt_ff == MS_LAST)
      begin
         msCnt_ff <= '0;
      end
      else
      begin
         msCnt_ff <= msCnt_ff + 1'b1;
      end
   end

   assign msTick = (msCnt_ff == MS_LAST);

   // Line state stability: count restarts on any D+ or D- change; once the
   // count reaches 1 ms the state counts as stable exactly once
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         lineCnt_ff   <= '0;
         lineArmed_ff <= 1'b0;
      end
      else if (!pinPrimed_ff || (lineNow != linePrev))
      begin
         lineCnt_ff   <= '0;
         lineArmed_ff <= 1'b1;
      end
      else if (lineSettled)
      begin
         lineCnt_ff   <= '0;
         lineArmed_ff <= 1'b0;
      end
      else if (lineArmed_ff)
      begin
         lineCnt_ff <= lineCnt_ff + 1'b1;
      end
   end

   assign lineSettled = lineArmed_ff && (lineCnt_ff == MS_LAST) && (lineNow == linePrev);

   // Last recorded stable line state, compared with each new stable state
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         lineStable_ff <= 2'b00;
      end
      else if (lineSettled)
      begin
         lineStable_ff <= lineNow;
      end
   end

   // Hardware events, one cycle each
   always_comb
   begin
      events = 8'h00;
      events[uef_pkg::ID_CHANGE_BIT] = pinChange[uef_pkg::PIN_ID];
      events[uef_pkg::MS_TIMER_BIT] = msTick;
      events[uef_pkg::LINE_STABLE_BIT] =
         lineSettled && (lineNow != lineStable_ff);
      // Wake-up only counts while software has armed it for low power
      events[uef_pkg::BUS_ACTIVITY_BIT] =
         control_ff[uef_pkg::WAKE_ARM_BIT] &&
         (pinChange[uef_pkg::PIN_ID] || pinChange[uef_pkg::PIN_DPLUS] ||
          pinChange[uef_pkg::PIN_DMINUS] ||
          pinChange[uef_pkg::PIN_SESS_VLD]);
      // Comparator high means VBUS is below the session end level
      events[uef_pkg::SESSION_VALID_BIT] =
         pinChange[uef_pkg::PIN_SESS_END] && pinSync[uef_pkg::PIN_SESS_END];
      events[uef_pkg::B_SESS_END_BIT] = pinChange[uef_pkg::PIN_SESS_END];
      events[uef_pkg::A_VBUS_VALID_BIT] = pinChange[uef_pkg::PIN_SESS_VLD];
   end

   // Software clears; a set alias never raises a flag, invert only lowers
   assign clears = wrFlags ? flagClears(flags_ff, regWrData[7:0], wrKind) : 8'h00;

   // An event in the same cycle as its clear keeps the flag set
   assign nxt_flags = ((flags_ff & ~clears) | events) & uef_pkg::EVENT_MASK;

   // Sticky event flags
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         flags_ff <= uef_pkg::EVENT_RESET;
      end
      else
      begin
         flags_ff <= nxt_flags;
      end
   end

   // Enable register with its aliases; bit 1 is not stored
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         enables_ff <= uef_pkg::EVENT_RESET;
      end
      else if (wrEnables)
      begin
         enables_ff <= applyWrite(enables_ff, regWrData[7:0],
                                  uef_pkg::EVENT_MASK, wrKind);
      end
   end

   // Control register with its aliases
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         control_ff <= uef_pkg::CONTROL_RESET;
      end
      else if (wrControl)
      begin
         control_ff <= applyWrite(control_ff, regWrData[7:0],
                                  uef_pkg::CONTROL_MASK, wrKind);
      end
   end

   // Read mux; aliases read the same value as their base register, and any
   // unmapped address reads zero
   always_comb
   begin
      nxt_rdData = uef_pkg::READ_ZERO;
      case (baseAddr)
         uef_pkg::FLAGS_OFS:   nxt_rdData = {uef_pkg::UPPER_ZERO, flags_ff};
         uef_pkg::ENABLES_OFS: nxt_rdData = {uef_pkg::UPPER_ZERO, enables_ff};
         uef_pkg::CONTROL_OFS: nxt_rdData = {uef_pkg::UPPER_ZERO, control_ff};
         uef_pkg::STATE_OFS:
            nxt_rdData = {uef_pkg::UPPER_ZERO, 1'b0, lineStable_ff, pinSync};
         default:              nxt_rdData = uef_pkg::READ_ZERO;
      endcase
   end

   // Read data stand only in the cycle after the read strobe
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         rdData_ff <= uef_pkg::READ_ZERO;
      end
      else if (regRead)
      begin
         rdData_ff <= nxt_rdData;
      end
      else
      begin
         rdData_ff <= uef_pkg::READ_ZERO;
      end
   end

   // Interrupt request; registered, so it trails the flag by one cycle
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         irq_ff <= 1'b0;
      end
      else
      begin
         irq_ff <= |(flags_ff & enables_ff);
      end
   end

   assign regRdData = rdData_ff;
   assign otgIrq    = irq_ff;

endmodule : uef_top

// [dv/uef_top_checker.sv]
`timescale 1ns/1ns
module uef_top_checker #(
   parameter int MS_CYCLES = 20
) (
   input wire logic        clock,
   input wire logic        rst_n,
   input wire logic [7:0]  regAddr,
   input wire logic [31:0] regWrData,
   input wire logic        regWrite,
   input wire logic        regRead,
   input wire logic [31:0] regRdData,
   input wire logic        idPin,
   input wire logic        dPlusPin,
   input wire logic        dMinusPin,
   input wire logic        sessValidCmp,
   input wire logic        sessEndCmp,
   input wire logic        otgIrq
);
   logic [7:0] enShadow_ff;
   logic [7:0] nxt_enShadow;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);
   // Shadow of the enables, so read-back and interrupt gating can be judged
   always_comb
   begin
      nxt_enShadow = enShadow_ff;
      if (regWrite && regAddr[7:4] == 4'h1)
      begin
         case (regAddr[3:2])
            2'h0: nxt_enShadow = regWrData[7:0];
            2'h1: nxt_enShadow = enShadow_ff & ~regWrData[7:0];
            2'h2: nxt_enShadow = enShadow_ff | regWrData[7:0];
            default: nxt_enShadow = enShadow_ff ^ regWrData[7:0];
         endcase
      end
   end
   always_ff @(posedge clock)
   begin
      if (!rst_n)
         enShadow_ff <= 8'h00;
      else
         enShadow_ff <= nxt_enShadow & 8'hfd;
   end
   a_rd_idle_zero: assert property (!$past(regRead) |-> regRdData == 32'h0)
      else $error("read data not zero outside read slot");
   a_upper_bits_zero: assert property (regRdData[31:8] == 24'h0)
      else $error("upper read bits not zero");
   a_bit_one_zero: assert property ($past(regRead) && $past(regAddr) < 8'h20 |-> !regRdData[1])
      else $error("bit 1 reads one");
   a_unmapped_zero: assert property ($past(regRead) && $past(regAddr) >= 8'h40 |-> regRdData == 32'h0)
      else $error("unmapped read not zero");
   a_enable_readback: assert property ($past(regRead) && $past(regAddr[7:4]) == 4'h1
      |-> regRdData == {24'h0, $past(enShadow_ff)})
      else $error("enable read-back mismatch");
   a_irq_needs_enable: assert property (enShadow_ff == 8'h00 |=> !otgIrq)
      else $error("interrupt with no enable set");
   a_irq_fall_cause: assert property ($fell(otgIrq) |-> $past(regWrite, 2))
      else $error("interrupt fell without a write");
   a_reset_clean: assert property ($rose(rst_n) |-> !otgIrq && regRdData == 32'h0)
      else $error("state not clean after reset");
   c_enable_read: cover property (regRead && regAddr == 8'h10);
   c_irq_rise: cover property ($rose(otgIrq));
   c_irq_fall: cover property ($fell(otgIrq));
endmodule : uef_top_checker

bind uef_top uef_top_checker #(.MS_CYCLES(MS_CYCLES)) u_uef_top_checker (.*);

// [dv/uef_xcvr_model.sv]
`timescale 1ns/1ns
// Transceiver and comparators; lines idle low (SE0, VBUS above session end level, below session valid)
module uef_xcvr_model (
   output logic idPin,
   output logic dPlusPin,
   output logic dMinusPin,
   output logic sessValidCmp,
   output logic sessEndCmp
);
   initial {idPin, dPlusPin, dMinusPin, sessValidCmp, sessEndCmp} = 5'h00;
   // Flip one line; caller calls just after a clock edge
   task automatic toggle(input int k);
      case (k)
         0: idPin <= ~idPin;
         1: sessValidCmp <= ~sessValidCmp;
         2: sessEndCmp <= ~sessEndCmp;
         3: dPlusPin <= ~dPlusPin;
         default: dMinusPin <= ~dMinusPin;
      endcase
   endtask : toggle
endmodule : uef_xcvr_model

// [dv/usb_otg_event_flags_bench.sv]
`timescale 1ns/1ns
module usb_otg_event_flags_bench;
   localparam int MS = 20;
   logic        clock     = 1'b0;
   logic        rst_n     = 1'b0;
   logic [7:0]  regAddr   = 8'h00;
   logic [31:0] regWrData = 32'h0;
   logic        regWrite  = 1'b0;
   logic        regRead   = 1'b0;
   logic [31:0] regRdData, got;
   logic        idPin, dPlusPin, dMinusPin, sessValidCmp, sessEndCmp, otgIrq;
   logic [7:0]  expEn, a;
   logic [31:0] d;
   int          k;
   int          n_fail     = 0;
   int          num_checks = 0;
   always #50 clock = ~clock;
   uef_top #(.MS_CYCLES(MS)) u_uef_top (.*);
   uef_xcvr_model u_uef_xcvr_model (.*);
   task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
      regWrite  <= 1'b1;
      regAddr   <= ad;
      regWrData <= dt;
      @(posedge clock);
      regWrite  <= 1'b0;
      // Let an edge pass so a following write never re-raises the strobe at once
      @(posedge clock);
   endtask : wr
   // Data stands only in the cycle after the strobe, so sample mid-cycle
   task automatic rd(input logic [7:0] ad);
      regRead <= 1'b1;
      regAddr <= ad;
      @(posedge clock);
      regRead <= 1'b0;
      @(negedge clock);
      got = regRdData;
      @(posedge clock);
   endtask : rd
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e)
      begin
         n_fail++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   task automatic irqChk(input int n, input logic e);
      repeat (n) @(posedge clock);
      @(negedge clock);
      chk({31'h0, otgIrq}, {31'h0, e});
      @(posedge clock);
   endtask : irqChk
   function automatic logic [7:0] aliasWr(input logic [7:0] c, input logic [7:0] ad,
                                          input logic [7:0] dt);
      case (ad[3:2])
         2'h0: return dt & 8'hfd;
         2'h1: return c & ~dt;
         2'h2: return (c | dt) & 8'hfd;
         default: return (c ^ dt) & 8'hfd;
      endcase
   endfunction : aliasWr
   // Flags expected with wake armed; the timer bit is masked off by the caller
   function automatic logic [7:0] evExp(input int ev, input logic lvl);
      case (ev)
         0: return 8'h90;
         1: return 8'h11;
         2: return lvl ? 8'h04 : 8'h0c;
         default: return 8'h30;
      endcase
   endfunction : evExp
   task automatic conclude();
      $display("checks %0d, failures %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : conclude
   initial
   begin
      #(100 * 20000);
      n_fail++;
      $display("watchdog expired");
      conclude();
   end
   initial
   begin
      void'($urandom(32'hf913));
      repeat (4) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      rd(8'h00); chk(got, 32'h0);
      rd(8'h10); chk(got, 32'h0);
      rd(8'h44); chk(got, 32'h0);
      $display("test reset done");
      expEn = 8'h00;
      for (int i = 0; i < 16; i++)
      begin
         a = 8'h10 + 8'(4 * (i % 4));
         d = (i == 0) ? 32'hffffffff : $urandom;
         wr(a, d);
         expEn = aliasWr(expEn, a, d[7:0]);
         rd(8'h10); chk(got, {24'h0, expEn});
      end
      wr(8'h14, 32'hff);
      $display("test enables done");
      wr(8'h20, 32'h1);
      for (int i = 0; i < 12; i++)
      begin
         k = (i < 5) ? i : int'($urandom % 5);
         a = evExp(k, sessEndCmp);
         wr(8'h00, 32'hff);
         u_uef_xcvr_model.toggle(k);
         repeat (MS + 15) @(posedge clock);
         rd(8'h00); chk(got & 32'hbf, {24'h0, a});
      end
      wr(8'h00, 32'h0);
      rd(8'h00); chk(got & 32'hbf, {24'h0, a});
      wr(8'h00, 32'hff);
      wr(8'h08, 32'hff);
      rd(8'h00); chk(got & 32'hbf, 32'h0);
      wr(8'h20, 32'h0);
      $display("test events done");
      repeat (MS + 4) @(posedge clock);
      rd(8'h00); chk(got & 32'h40, 32'h40);
      $display("test timer done");
      wr(8'h10, 32'h80);
      wr(8'h00, 32'hff);
      irqChk(MS + 4, 1'b0);
      u_uef_xcvr_model.toggle(0);
      irqChk(8, 1'b1);
      wr(8'h14, 32'h80);
      irqChk(2, 1'b0);
      wr(8'h18, 32'h80);
      irqChk(2, 1'b1);
      wr(8'h00, 32'h80);
      irqChk(2, 1'b0);
      wr(8'h10, 32'h40);
      irqChk(MS + 4, 1'b1);
      $display("test interrupt done");
      wr(8'h10, 32'hff);
      rst_n <= 1'b0;
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      rd(8'h10); chk(got, 32'h0);
      rd(8'h00); chk(got, 32'h0);
      $display("test second reset done");
      conclude();
   end
endmodule : usb_otg_event_flags_bench
